// ### pcd_pkg.sv
// package of register map, field positions and reset values for the pin change detector
package pcd_pkg;
    // number of monitored port pins
    localparam int PCD_PINS = 8;
    // apb geometry
    localparam int PCD_ADDR_W = 8;
    localparam int PCD_DATA_W = 32;
    // register byte addresses
    localparam logic [7:0] PCD_RISE_OFS = 8'h00;
    localparam logic [7:0] PCD_FALL_OFS = 8'h04;
    localparam logic [7:0] PCD_FLAG_OFS = 8'h08;
    localparam logic [7:0] PCD_CTRL_OFS = 8'h0c;
    localparam logic [7:0] PCD_STAT_OFS = 8'h10;
    localparam logic [7:0] PCD_MASK_OFS = 8'h14;
    // control register fields
    localparam int PCD_CTRL_MASTER_BIT = 0;
    localparam int PCD_CTRL_SUMMARY_BIT = 1;
    // reset values
    localparam logic [7:0] PCD_RISE_RST = 8'h00;
    localparam logic [7:0] PCD_FALL_RST = 8'h00;
    localparam logic [7:0] PCD_FLAG_RST = 8'h00;
    localparam logic PCD_MASTER_RST = 1'b0;
    localparam logic [7:0] PCD_STAT_RST = 8'h00;
    localparam logic [7:0] PCD_MASK_RST = 8'h00;
    localparam logic [31:0] PCD_RDATA_RST = 32'h0000_0000;
endpackage

// ### pcd_detector.sv
// port pin change detector: edge detect, flags, master enable, wake and apb registers
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module pcd_detector
    import pcd_pkg::*;
#(
    parameter int Pins = PCD_PINS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PCD_ADDR_W-1:0] paddr,
    input wire logic [PCD_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [PCD_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [Pins-1:0] monitoredPin,
    input wire logic sleepMode,
    output logic changeIrq,
    output logic changeSummaryFlag,
    output logic wakeReq,
    output logic irq
);

    // refuse any pin count other than the 8 the registers are sized for
    if (Pins != PCD_PINS) begin : gPinCheck
        $error("pcd_detector: Pins must equal the register width");
    end

    // whole state of the block
    typedef struct packed {
        logic [Pins-1:0] sync1;
        logic [Pins-1:0] sync2;
        logic [Pins-1:0] prev;
        logic [Pins-1:0] riseEn;
        logic [Pins-1:0] fallEn;
        logic [Pins-1:0] flags;
        logic master;
        logic [Pins-1:0] stat;
        logic [Pins-1:0] mask;
        logic [PCD_DATA_W-1:0] rdata;
        logic slvErr;
        logic wake;
    } pcd_state_s;

    pcd_state_s q;
    pcd_state_s d;

    logic [Pins-1:0] riseP;
    logic [Pins-1:0] fallP;
    logic [Pins-1:0] setVec;
    logic setupPh;
    logic accessPh;
    logic wrAcc;
    logic rdAcc;
    logic hitRise;
    logic hitFall;
    logic hitFlag;
    logic hitCtrl;
    logic hitStat;
    logic hitMask;
    logic mapped;
    logic wrLane0;
    logic wrFlags;
    logic rdStat;

    // per-pin edge pulses and arming
    for (genvar i = 0; i < Pins; i++) begin : gPin
        assign riseP[i] = q.sync2[i] & ~q.prev[i];
        assign fallP[i] = ~q.sync2[i] & q.prev[i];
        // each polarity gated by its own enable, both may be armed at once
        assign setVec[i] = (riseP[i] & q.riseEn[i]) | (fallP[i] & q.fallEn[i]);
    end

    // apb phase and address decode
    assign setupPh = psel & ~penable;
    assign accessPh = psel & penable;
    assign wrAcc = accessPh & pwrite;
    assign rdAcc = accessPh & ~pwrite;
    assign hitRise = (paddr == PCD_RISE_OFS);
    assign hitFall = (paddr == PCD_FALL_OFS);
    assign hitFlag = (paddr == PCD_FLAG_OFS);
    assign hitCtrl = (paddr == PCD_CTRL_OFS);
    assign hitStat = (paddr == PCD_STAT_OFS);
    assign hitMask = (paddr == PCD_MASK_OFS);
    assign mapped = hitRise | hitFall | hitFlag | hitCtrl | hitStat | hitMask;
    assign wrLane0 = wrAcc & pstrb[0];
    assign wrFlags = wrLane0 & hitFlag;
    assign rdStat = rdAcc & hitStat;

    // next-state logic
    always_comb begin
        d = q;
        // two-stage synchroniser, then the previous sample
        d.sync1 = monitoredPin;
        d.sync2 = q.sync1;
        d.prev = q.sync2;
        // edge enable, control and mask registers
        if (wrLane0 && hitRise) begin
            d.riseEn = pwdata[Pins-1:0];
        end
        if (wrLane0 && hitFall) begin
            d.fallEn = pwdata[Pins-1:0];
        end
        if (wrLane0 && hitCtrl) begin
            d.master = pwdata[PCD_CTRL_MASTER_BIT];
        end
        if (wrLane0 && hitMask) begin
            d.mask = pwdata[Pins-1:0];
        end
        // flags: a written zero clears, a one keeps; the edge set is or'ed last
        if (wrFlags) begin
            d.flags = q.flags & pwdata[Pins-1:0];
        end
        d.flags = d.flags | setVec;
        // status: clear only what the read returned, new events still land
        if (rdStat) begin
            d.stat = q.stat & ~q.rdata[Pins-1:0];
        end
        d.stat = d.stat | setVec;
        // read data and error captured in the setup cycle
        if (setupPh) begin
            d.slvErr = ~mapped;
            d.rdata = PCD_RDATA_RST;
            if (!pwrite) begin
                unique case (1'b1)
                    hitRise: d.rdata[Pins-1:0] = q.riseEn;
                    hitFall: d.rdata[Pins-1:0] = q.fallEn;
                    hitFlag: d.rdata[Pins-1:0] = q.flags;
                    hitCtrl: begin
                        d.rdata[PCD_CTRL_MASTER_BIT] = q.master;
                        d.rdata[PCD_CTRL_SUMMARY_BIT] = |q.flags;
                    end
                    hitStat: d.rdata[Pins-1:0] = q.stat;
                    hitMask: d.rdata[Pins-1:0] = q.mask;
                    default: d.rdata = PCD_RDATA_RST;
                endcase
            end
        end
        // wake raised together with the flag it reports
        d.wake = sleepMode & q.master & (|setVec);
    end

    // state register with synchronous active-low reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q.sync1 <= '0;
            q.sync2 <= '0;
            q.prev <= '0;
            q.riseEn <= PCD_RISE_RST;
            q.fallEn <= PCD_FALL_RST;
            q.flags <= PCD_FLAG_RST;
            q.master <= PCD_MASTER_RST;
            q.stat <= PCD_STAT_RST;
            q.mask <= PCD_MASK_RST;
            q.rdata <= PCD_RDATA_RST;
            q.slvErr <= 1'b0;
            q.wake <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // outputs
    assign prdata = q.rdata;
    assign pready = 1'b1; // zero wait states
    assign pslverr = q.slvErr & accessPh;
    assign changeSummaryFlag = |q.flags;
    assign changeIrq = q.master & (|q.flags);
    assign wakeReq = q.wake;
    assign irq = |(q.stat & q.mask);

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence edgeInSleep;
        sleepMode && q.master && (setVec != '0);
    endsequence

    sequence pinZeroRise;
        ($rose(monitoredPin[0]) && q.riseEn[0]) ##1 (monitoredPin[0] && q.riseEn[0]) [*2];
    endsequence

    flag_set_a: assert property (
        (setVec != '0) |=> ((q.flags & $past(setVec)) == $past(setVec)))
        else $error("enabled edge did not set its flag");

    flag_cause_a: assert property (
        ((q.flags & ~$past(q.flags)) & ~$past(setVec)) == '0)
        else $error("flag rose without an enabled edge");

    irq_gate_a: assert property (
        changeIrq == (q.master && (q.flags != '0)))
        else $error("change interrupt not gated by master enable");

    summary_or_a: assert property (
        (setVec != '0) |=> changeSummaryFlag)
        else $error("summary flag missed a set pin flag");

    flag_write_a: assert property (
        wrFlags |=> (q.flags == (($past(q.flags) & $past(pwdata[Pins-1:0])) | $past(setVec))))
        else $error("flag write did not clear written zeros");

    set_wins_a: assert property (
        (wrFlags && (setVec != '0)) |=> ((q.flags & $past(setVec)) == $past(setVec)))
        else $error("clear beat a simultaneous edge");

    sleep_wake_a: assert property (
        edgeInSleep |=> (wakeReq && ((q.flags & $past(setVec)) == $past(setVec))))
        else $error("edge in sleep did not wake with flag set");

    pin_sync_a: assert property (
        pinZeroRise |=> q.flags[0])
        else $error("rising pin not flagged after synchroniser delay");

    reset_zero_a: assert property (
        $rose(rst_b) |-> (q.riseEn == '0 && q.fallEn == '0 && q.flags == '0))
        else $error("registers not cleared by reset");

    stat_clear_a: assert property (
        rdStat |=> ((q.stat & $past(q.rdata[Pins-1:0]) & ~$past(setVec)) == '0))
        else $error("status read did not clear reported bits");

    // arming and polarity of the set pulses
    rise_only_a: assert property (
        ((setVec & q.sync2) & ~q.riseEn) == '0)
        else $error("rising set without rising enable");

    fall_only_a: assert property (
        ((setVec & ~q.sync2) & ~q.fallEn) == '0)
        else $error("falling set without falling enable");

    both_edges_a: assert property (
        ((q.sync2 ^ q.prev) & q.riseEn & q.fallEn & ~setVec) == '0)
        else $error("edge missed on a pin armed for both polarities");

    edge_real_a: assert property (
        (setVec & ~(q.sync2 ^ q.prev)) == '0)
        else $error("set pulse without a sampled change");

    any_mix_a: assert property (
        (((q.sync2 & ~q.prev & q.riseEn) | (~q.sync2 & q.prev & q.fallEn)) & ~setVec) == '0)
        else $error("armed pin change not turned into a set pulse");

    // master enable, summary and interrupt outputs
    master_off_a: assert property (
        !q.master |-> !changeIrq)
        else $error("change interrupt raised with master enable clear");

    master_flags_a: assert property (
        (!q.master && (setVec != '0)) |=> changeSummaryFlag)
        else $error("flag not set while master enable clear");

    summary_zero_a: assert property (
        (q.flags == '0) |-> !changeSummaryFlag)
        else $error("summary flag set with no pin flag");

    irq_mask_a: assert property (
        (q.mask == '0) |-> !irq)
        else $error("interrupt raised with every mask bit clear");

    // flag register writes and hardware sets
    flag_hold_a: assert property (
        !wrFlags |=> ((q.flags & $past(q.flags)) == $past(q.flags)))
        else $error("flag dropped without a software write");

    flag_keep_a: assert property (
        wrFlags |=> ((q.flags & $past(q.flags) & $past(pwdata[Pins-1:0]))
            == ($past(q.flags) & $past(pwdata[Pins-1:0]))))
        else $error("written one cleared a flag");

    race_keep_a: assert property (
        (wrFlags && (pwdata[Pins-1:0] == '0) && (setVec != '0))
            |=> (q.flags == $past(setVec)))
        else $error("clearing write lost a coincident edge");

    stat_set_a: assert property (
        (setVec != '0) |=> ((q.stat & $past(setVec)) == $past(setVec)))
        else $error("enabled edge did not set its status bit");

    // edge enable and control registers
    rise_write_a: assert property (
        (wrLane0 && hitRise) |=> (q.riseEn == $past(pwdata[Pins-1:0])))
        else $error("rising enable write did not land");

    fall_write_a: assert property (
        (wrLane0 && hitFall) |=> (q.fallEn == $past(pwdata[Pins-1:0])))
        else $error("falling enable write did not land");

    rise_hold_a: assert property (
        !(wrLane0 && hitRise) |=> $stable(q.riseEn))
        else $error("rising enable changed without a write");

    ctrl_write_a: assert property (
        (wrLane0 && hitCtrl) |=> (q.master == $past(pwdata[PCD_CTRL_MASTER_BIT])))
        else $error("master enable write did not land");

    strobe_off_a: assert property (
        (wrAcc && !pstrb[0]) |=> ($stable(q.riseEn) && $stable(q.fallEn) && $stable(q.mask)))
        else $error("write with lane zero off changed a register");

    // wake request
    wake_master_a: assert property (
        wakeReq |-> $past(q.master))
        else $error("wake raised with master enable clear");

    wake_sleep_a: assert property (
        wakeReq |-> $past(sleepMode))
        else $error("wake raised outside sleep");

    wake_flag_a: assert property (
        wakeReq |-> changeSummaryFlag)
        else $error("wake raised before the flag was updated");

    // bus answers
    slverr_set_a: assert property (
        (accessPh && !mapped) |-> pslverr)
        else $error("unmapped access without error");

    slverr_clear_a: assert property (
        (accessPh && mapped) |-> !pslverr)
        else $error("mapped access flagged as error");

    rdata_flags_a: assert property (
        (rdAcc && hitFlag) |-> (prdata[Pins-1:0] == $past(q.flags)))
        else $error("flag read returned a stale value");

    rdata_upper_a: assert property (
        prdata[PCD_DATA_W-1:Pins] == '0)
        else $error("unused read data bits not zero");

endmodule

// ### pcd_pin_driver.sv
// model of the external source that drives the monitored port pins
`timescale 1ns/1ns
module pcd_pin_driver (
    input wire logic clk,
    input wire logic [7:0] level,
    output logic [7:0] pins
);
    // the pins move just after a clock edge; any mix of them may change at once
    always @(posedge clk) begin
        pins <= level;
    end
endmodule

// ### port_pin_change_detector_bench.sv
// self-checking bench for the pin change detector with a behavioural model
`timescale 1ns/1ns
module port_pin_change_detector_bench;
    import pcd_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic sleepMode = 1'b0, err, pready, pslverr, changeIrq, changeSummaryFlag, wakeReq, irq;
    logic [7:0] paddr = 8'h00, level = 8'h00, pins;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int n_errors = 0, n_compared = 0, nWake = 0;
    int riseEn = 0, fallEn = 0, flags = 0, stat = 0, mask = 0, master = 0, prev = 0, obs;

    // clock, wake pulse counter and overall limit
    always #5 clk = ~clk;
    always @(posedge clk) if (wakeReq === 1'b1) nWake++;
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        results();
    end

    pcd_pin_driver u_pins (.clk(clk), .level(level), .pins(pins));
    pcd_detector u_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .monitoredPin(pins), .sleepMode(sleepMode),
        .changeIrq(changeIrq), .changeSummaryFlag(changeSummaryFlag), .wakeReq(wakeReq),
        .irq(irq));

    task results;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one apb transfer: setup, then access held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            n_errors++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask

    // new pin level; the model records every enabled edge
    task drive(input logic [7:0] v);
        int ev;
        ev = ((~prev & v & riseEn) | (prev & ~v & fallEn)) & 8'hff;
        flags |= ev;
        stat |= ev;
        prev = v;
        @(posedge clk);
        level <= v;
        repeat (6) @(posedge clk);
    endtask

    task outs;
        @(posedge clk);
        chk("summary", flags != 0, changeSummaryFlag);
        chk("changeIrq", master != 0 && flags != 0, changeIrq);
        chk("irq", (stat & mask) != 0, irq);
    endtask

    initial begin
        void'($urandom(43));
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        rdc("rise", PCD_RISE_OFS, 32'h0);
        rdc("fall", PCD_FALL_OFS, 32'h0);
        rdc("flags", PCD_FLAG_OFS, 32'h0);
        apb(1'b0, 8'h3c, 32'h0);
        chk("slverr", 32'h1, err);
        $display("test reset done");
        // random arming, pin traffic and partial clears
        for (int k = 0; k < 8; k++) begin
            riseEn = $urandom & 8'hff;
            fallEn = $urandom & 8'hff;
            master = k % 2;
            apb(1'b1, PCD_RISE_OFS, riseEn);
            apb(1'b1, PCD_FALL_OFS, fallEn);
            apb(1'b1, PCD_CTRL_OFS, master);
            drive($urandom);
            drive($urandom);
            rdc("flags", PCD_FLAG_OFS, flags);
            rdc("rise", PCD_RISE_OFS, riseEn);
            rdc("ctrl", PCD_CTRL_OFS, master | ((flags != 0) << 1));
            outs();
            obs = flags & $urandom;
            flags &= ~obs;
            apb(1'b1, PCD_FLAG_OFS, flags);
            rdc("cleared", PCD_FLAG_OFS, flags);
        end
        $display("test arming done");
        // an edge lands while software writes zero to the flags
        riseEn = 8'hff;
        fallEn = 8'hff;
        apb(1'b1, PCD_RISE_OFS, riseEn);
        apb(1'b1, PCD_FALL_OFS, fallEn);
        level <= ~prev;
        prev = ~prev & 8'hff;
        flags = 8'hff;
        stat |= 8'hff;
        // one edge of delay puts the set pulse on the access edge of the write
        @(posedge clk);
        apb(1'b1, PCD_FLAG_OFS, 32'h0);
        repeat (6) @(posedge clk);
        rdc("race", PCD_FLAG_OFS, flags);
        $display("test race done");
        // status is read-cleared and gated by the mask
        mask = $urandom & 8'hff;
        apb(1'b1, PCD_MASK_OFS, mask);
        outs();
        rdc("stat", PCD_STAT_OFS, stat);
        stat = 0;
        outs();
        $display("test status done");
        // wake from sleep needs the master enable
        master = 1;
        apb(1'b1, PCD_CTRL_OFS, 32'h1);
        sleepMode <= 1'b1;
        nWake = 0;
        drive(~prev);
        chk("wake", 32'h1, nWake);
        master = 0;
        apb(1'b1, PCD_CTRL_OFS, 32'h0);
        drive(~prev);
        chk("nowake", 32'h1, nWake);
        sleepMode <= 1'b0;
        rdc("wakeflags", PCD_FLAG_OFS, flags);
        outs();
        $display("test sleep done");
        results();
    end
endmodule
